// File: hdl/fan_commutation_control.sv
// fan_commutation_control: single-coil fan commutation, pwm gating, lock retry, standby
// assumes pole, pwm and overvoltage come from outside the clock domain
// Functional notes
// R01: tach output toggles on each pole change while in run state
// R02: south lock: b low, a pulses on/off
// R03: north lock: a low, b pulses on/off
// R04: pwm low over 65 ms drives both low
// R05: long pwm low clears off-time, enters standby
// R06: first pwm high after standby starts on-time
// R07: sensor settles 100 us after standby exit
// R08: standby releases tach switch high
// R09: overvoltage switches drive off, enters standby
// R10: drive duty follows pwm input duty
// R11: host pwm frequency 50 Hz to 50 kHz
// R12: host pwm near 25 kHz recommended
// R13: pwm held high gives full duty
// R14: coil current ramps at each commutation
// R15: lock on-time is 420 ms
// R16: lock off-time is ten on-times
// R17: no pole change in on-time means lock
// R18: pwm and pole synchronised before use
`timescale 1ns/1ps
module fan_commutation_control
  import fan_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_pole_south,
  input wire logic i_pwm,
  input wire logic i_overvoltage,
  output logic o_coil_drive_a,
  output logic o_coil_drive_b,
  output logic o_tach_output_oe,
  output logic o_tach_output
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] rst_q;
  logic rst_n;
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  logic pole;
  logic pwm;
  logic ovp;
  sync3 #(.INIT(1'b0)) u_pole (.i_clock(i_clock), .i_rst_n(rst_n), .i_async(i_pole_south), .o_level(pole)); // [R18]
  sync3 #(.INIT(1'b0)) u_pwm (.i_clock(i_clock), .i_rst_n(rst_n), .i_async(i_pwm), .o_level(pwm)); // [R18]
  // overvoltage is a pin as well, so it passes the same filter
  sync3 #(.INIT(1'b0)) u_ovp (.i_clock(i_clock), .i_rst_n(rst_n), .i_async(i_overvoltage), .o_level(ovp));

  ////////////////////////////////////////////////////////////////////////////
  // pwm low watchdog
  // saturates one past the limit, so a long stop never wraps back to zero
  logic [CNT_W-1:0] low_cnt_q;
  logic [CNT_W-1:0] low_cnt_d;
  logic pwm_long_low;
  always_comb begin
    low_cnt_d = low_cnt_q;
    if (pwm) begin
      low_cnt_d = '0;
    end else if (low_cnt_q <= CNT_W'(PWM_LOW_CYCLES)) begin
      low_cnt_d = low_cnt_q + CNT_W'(1);
    end
  end
  assign pwm_long_low = (low_cnt_q > CNT_W'(PWM_LOW_CYCLES)); // [R04] [R05]

  ////////////////////////////////////////////////////////////////////////////
  // main state machine
  fan_state_type state_q;
  fan_state_type state_d;
  logic [CNT_W-1:0] tmr_q;
  logic [CNT_W-1:0] tmr_d;
  logic pole_q;
  logic pole_d;
  logic lock_pole_q;
  logic lock_pole_d;
  logic pole_edge;
  assign pole_edge = (pole != pole_q);

  always_comb begin
    state_d = state_q;
    tmr_d = tmr_q + CNT_W'(1);
    pole_d = pole_q;
    lock_pole_d = lock_pole_q;
    unique case (state_q)
      ST_STANDBY: begin
        tmr_d = '0;
        if (pwm && !ovp) begin
          state_d = ST_SETTLE; // [R06]
        end
      end
      ST_SETTLE: begin
        if (tmr_q >= CNT_W'(SETTLE_CYCLES - 1)) begin // [R07]
          state_d = ST_LOCK_ON; // [R06]
          tmr_d = '0;
          pole_d = pole;
          lock_pole_d = pole;
        end
      end
      ST_LOCK_ON, ST_RUN: begin
        if (pole_edge) begin
          pole_d = pole;
          lock_pole_d = pole;
          tmr_d = '0;
          state_d = ST_RUN;
        end else if (tmr_q >= CNT_W'(LOCK_ON_CYCLES - 1)) begin // [R15] [R17]
          state_d = ST_LOCK_OFF;
          tmr_d = '0;
        end
      end
      ST_LOCK_OFF: begin
        if (tmr_q >= CNT_W'(LOCK_ON_CYCLES * LOCK_OFF_RATIO - 1)) begin // [R16] [R17]
          state_d = ST_LOCK_ON;
          tmr_d = '0;
          pole_d = pole;
          lock_pole_d = pole;
        end
      end
      default: begin
        state_d = ST_STANDBY;
      end
    endcase
    // protection wins over every state, so no path leaves the bridge on
    if (ovp || pwm_long_low) begin
      state_d = ST_STANDBY; // [R05] [R09]
      tmr_d = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // soft switching ramp and pwm frame for gating
  logic [4:0] ramp_q;
  logic [4:0] ramp_d;
  logic [CNT_W-1:0] step_q;
  logic [CNT_W-1:0] step_d;
  logic [5:0] frame_q;
  logic [5:0] frame_d;
  logic drive_on;
  logic want_a;
  logic want_b;
  logic a_d;
  logic b_d;
  logic tach_d;
  logic tach_q;
  logic a_q;
  logic b_q;
  logic oe_d;
  logic oe_q;

  always_comb begin
    frame_d = frame_q + 6'h01;
    step_d = step_q + CNT_W'(1);
    ramp_d = ramp_q;
    if (state_q != state_d || pole_edge) begin
      ramp_d = 5'h00; // [R14]
      step_d = '0;
    end else if (step_q >= CNT_W'(SOFT_STEP_CYCLES - 1)) begin
      step_d = '0;
      if (ramp_q != SOFT_FULL) begin
        ramp_d = ramp_q + 5'h01; // [R14]
      end
    end
    // ramp as a duty fraction over a short frame; a coarse stand-in for analog slew
    drive_on = pwm && ({1'b0, ramp_q, 2'h0} > {2'h0, frame_q} || ramp_q == SOFT_FULL); // [R10] [R13] [R14]
    want_a = 1'b0;
    want_b = 1'b0;
    if (state_q == ST_RUN || state_q == ST_LOCK_ON) begin
      want_a = (state_q == ST_RUN) ? pole_q : lock_pole_q; // [R02]
      want_b = (state_q == ST_RUN) ? !pole_q : !lock_pole_q; // [R03]
    end
    a_d = want_a && drive_on && !ovp && !pwm_long_low; // [R04] [R09]
    b_d = want_b && drive_on && !ovp && !pwm_long_low; // [R04] [R09]
    // tach follows commutation, not pwm chopping
    tach_d = tach_q;
    if (state_q == ST_RUN && pole_edge) begin
      tach_d = !tach_q; // [R01]
    end
    if (state_q == ST_STANDBY) begin
      tach_d = 1'b1; // [R08]
    end
    oe_d = !tach_d;
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_q <= '0;
      state_q <= ST_STANDBY;
      tmr_q <= '0;
      pole_q <= 1'b0;
      lock_pole_q <= 1'b0;
      ramp_q <= 5'h00;
      step_q <= '0;
      frame_q <= 6'h00;
      a_q <= 1'b0;
      b_q <= 1'b0;
      tach_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      low_cnt_q <= low_cnt_d;
      state_q <= state_d;
      tmr_q <= tmr_d;
      pole_q <= pole_d;
      lock_pole_q <= lock_pole_d;
      ramp_q <= ramp_d;
      step_q <= step_d;
      frame_q <= frame_d;
      a_q <= a_d;
      b_q <= b_d;
      tach_q <= tach_d;
      oe_q <= oe_d;
    end
  end

  assign o_coil_drive_a = a_q;
  assign o_coil_drive_b = b_q;
  assign o_tach_output_oe = oe_q;
  assign o_tach_output = 1'b0;
endmodule

// File: hdl/fan_pkg.sv
// fan_pkg: constants shared by the fan commutation control design
// assumes a 40 MHz time base clock
package fan_pkg;
  localparam int CLOCK_HZ = 40_000_000;
  localparam int PWM_LOW_MS = 65;
  localparam int PWM_LOW_CYCLES = CLOCK_HZ / 1000 * PWM_LOW_MS;
  localparam int SETTLE_US = 100;
  localparam int SETTLE_CYCLES = (CLOCK_HZ / 1_000_000) * SETTLE_US;
  localparam int LOCK_ON_MS = 420;
  localparam int LOCK_ON_CYCLES = CLOCK_HZ / 1000 * LOCK_ON_MS;
  localparam int LOCK_OFF_RATIO = 10;
  localparam int SOFT_SWITCH_US = 200;
  localparam int SOFT_CYCLES = (CLOCK_HZ / 1_000_000) * SOFT_SWITCH_US;
  localparam int SOFT_STEPS = 16;
  localparam int SOFT_STEP_CYCLES = SOFT_CYCLES / SOFT_STEPS;
  localparam int PWM_FRAME_CYCLES = 64;
  localparam int CNT_W = 32;
  localparam logic [4:0] SOFT_FULL = 5'h10;
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_SETTLE = 3'b001,
    ST_LOCK_ON = 3'b011,
    ST_RUN = 3'b010,
    ST_LOCK_OFF = 3'b111
  } fan_state_type;
endpackage

// File: hdl/sync3.sv
// sync3: three-stage input synchroniser; a change counts once stages two and three agree
// assumes one clock and an active-low reset already synchronised
`timescale 1ns/1ps
module sync3 #(parameter logic INIT = 1'b0) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_async,
  output logic o_level
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic lvl_q;
  logic lvl_d;
  always_comb begin
    sh_d = {sh_q[1:0], i_async};
    lvl_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_q <= {3{INIT}};
      lvl_q <= INIT;
    end else begin
      sh_q <= sh_d;
      lvl_q <= lvl_d;
    end
  end
  assign o_level = lvl_q;
endmodule

// File: test/fan_checker_properties.sv
// fan_checker: port-level assertions for the fan commutation control
// bound to every instance; sees only the top module's ports
`timescale 1ns/1ps
module fan_checker (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_pole_south,
  input wire logic i_pwm,
  input wire logic i_overvoltage,
  input wire logic o_coil_drive_a,
  input wire logic o_coil_drive_b,
  input wire logic o_tach_output_oe,
  input wire logic o_tach_output
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  logic idle;
  assign idle = !o_coil_drive_a && !o_coil_drive_b;
  ////////////////////////////////////////////////////////////
  // eight cycles covers the 3-4 cycle sync plus the output register
  sequence s_pwm_low;
    !i_pwm [*8];
  endsequence
  sequence s_ovp_on;
    i_overvoltage [*8];
  endsequence
  a_drive_excl: assert property (!(o_coil_drive_a && o_coil_drive_b))
    else $error("both coil outputs driven");
  a_pwm_gate: assert property (s_pwm_low |-> idle)
    else $error("drive while pwm low");
  a_ovp_off: assert property (s_ovp_on |-> idle)
    else $error("drive during overvoltage");
  a_ovp_tach: assert property (s_ovp_on |-> !o_tach_output_oe)
    else $error("tach held low in standby");
  a_tach_data: assert property (o_tach_output == 1'b0)
    else $error("open-drain data not low");
  a_settle_wait: assert property (s_ovp_on ##1 !i_overvoltage |-> idle [*8])
    else $error("drive before sensor settled");
  a_reset_idle: assert property ($rose(i_reset_n) |-> (idle && !o_tach_output_oe) [*3])
    else $error("outputs active after reset");
  a_tach_pole: assert property ($rose(o_tach_output_oe) |-> $past(i_pole_south, 2) != $past(i_pole_south, 8))
    else $error("tach toggle without pole edge");
endmodule
bind fan_commutation_control fan_checker chk (.i_clock, .i_reset_n, .i_pole_south, .i_pwm, .i_overvoltage,
  .o_coil_drive_a, .o_coil_drive_b, .o_tach_output_oe, .o_tach_output);

// File: test/fan_partner.sv
// fan_partner: host pwm source and a rotor whose pole turns while driven
// assumes the bench sets duty and spin; changes land on the falling edge
`timescale 1ns/1ps
module fan_partner #(parameter int PWM_PERIOD = 1600, parameter int HALF_TURN = 9000) (
  input wire logic i_clock,
  input wire logic i_coil_a,
  input wire logic i_coil_b,
  input wire logic i_spin,
  input wire integer i_duty,
  output logic o_pwm,
  output logic o_pole_south
);
  int ph = 0;
  int rot = 0;
  initial begin
    o_pwm = 1'b0;
    o_pole_south = 1'b1;
  end
  // 1600 cycles is 25 kHz, inside the accepted band
  always @(negedge i_clock) begin
    ph <= (ph + 1) % PWM_PERIOD;
    o_pwm <= (ph < i_duty);
    if (i_spin && (i_coil_a || i_coil_b)) begin
      rot <= rot + 1;
    end
    if (rot >= HALF_TURN) begin
      rot <= 0;
      o_pole_south <= !o_pole_south;
    end
  end
endmodule

// File: test/fan_commutation_control_tb.sv
// fan_commutation_control_tb: self-checking bench with partner rotor and pwm
// assumes 40 MHz clock; lock and long-low counts are too long to simulate
`timescale 1ns/1ps
module fan_commutation_control_tb
  import fan_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ovp = 1'b0;
  logic spin = 1'b0;
  int duty = 0;
  logic pwm, pole, a, b, oe, tach;
  logic [2:0] exp_q[$];
  event probe;
  int n_mismatch = 0;
  int check_count = 0;
  int na, np;
  initial forever #12.5 clk = ~clk;
  fan_partner far (.i_clock(clk), .i_coil_a(a), .i_coil_b(b), .i_spin(spin), .i_duty(duty),
    .o_pwm(pwm), .o_pole_south(pole));
  fan_commutation_control uut (.i_clock(clk), .i_reset_n(rst_n), .i_pole_south(pole), .i_pwm(pwm),
    .i_overvoltage(ovp), .o_coil_drive_a(a), .o_coil_drive_b(b), .o_tach_output_oe(oe), .o_tach_output(tach));
  ////////////////////////////////////////////////////////////
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic note(input logic [2:0] e);
    exp_q.push_back(e);
    ->probe;
  endtask
  task automatic compare_pins(input logic [2:0] got, input logic [2:0] want);
    check_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("Error %0t pins %b want %b", $time, got, want);
    end
  endtask
  task automatic compare_count(input int got, input int want);
    check_count++;
    if (got > want + 48 || got + 48 < want) begin
      n_mismatch++;
      $display("Error %0t drive cycles %0d pwm cycles %0d", $time, got, want);
    end
  endtask
  task automatic compare_range(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("Error %0t drive cycles %0d outside %0d to %0d", $time, got, lo, hi);
    end
  endtask
  // an unknown on either coil output counts as drive, so it cannot hide in a zero count
  task automatic count_drive(input int n);
    na = 0;
    np = 0;
    repeat (n) begin
      @(negedge clk);
      na += (a !== 1'b0 || b !== 1'b0);
      np += pwm;
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial forever begin
    @(probe);
    compare_pins({a, b, oe}, exp_q.pop_front());
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(7));
    wait_n(8);
    rst_n = 1'b1;
    wait_n(4);
    note(3'b000);
    $display("test standby done");
    duty = 1600;
    count_drive(3990);
    compare_range(na, 0, 0);
    note(3'b000);
    count_drive(9000);
    compare_range(na, 9000 - SOFT_CYCLES, 9000 - SOFT_CYCLES / 4);
    note(3'b100);
    $display("test start done");
    spin = 1'b1;
    for (int k = 1; k <= 4; k++) begin
      @(pole);
      wait_n(8500);
      note({pole, !pole, 1'((k - 1) & 1)});
    end
    spin = 1'b0;
    $display("test spin done");
    repeat (2) begin
      duty = $urandom_range(400, 1500);
      count_drive(6400);
      compare_count(na, np);
    end
    $display("test duty done");
    ovp = 1'b1;
    wait_n(10);
    note(3'b000);
    ovp = 1'b0;
    wait_n(20);
    note(3'b000);
    $display("test overvoltage done");
    end_of_test();
  end
endmodule
